/* File: verilog/wdt_timer.v */
// Watchdog timer with wake-up, APB register slave
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`include "wdt_defs.vh"

module wdt_timer #(
  parameter CNT_W = `WDT_CNT_W,
  parameter GRACE_CLKS = `WDT_GRACE_CLKS,
  parameter RST_CLKS = `WDT_RST_CLKS
) (
  input wire pclk,
  input wire presetn,
  input wire wd_clock,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire power_down,
  output wire timeout_irq,
  output wire wake_req,
  output wire chip_reset_n,
  output wire [31:0] reset_vector
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Interval in watchdog clocks minus one, 2^(4+2*sel)
  function [CNT_W-1:0] interval_last;
    input [2:0] sel;
    reg [CNT_W:0] one_hot;
    begin
      one_hot = {{CNT_W{1'b0}}, 1'b1} << (5'd4 + {1'b0, sel, 1'b0});
      interval_last = one_hot[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2:0] wdc_sync_r;
  reg wd_enable_r;
  reg wd_reset_enable_r;
  reg timeout_int_enable_r;
  reg wake_enable_r;
  reg [2:0] interval_select_r;
  reg counter_clear_r;
  reg timeout_int_flag_r;
  reg wd_reset_flag_r;
  reg wake_flag_r;
  reg [CNT_W-1:0] count_r;
  reg grace_active_r;
  reg [10:0] grace_cnt_r;
  reg rst_active_r;
  reg [6:0] rst_cnt_r;
  reg [31:0] prdata_r;
  reg wake_req_r;
  reg [CNT_W-1:0] count_nxt;
  reg grace_active_nxt;
  reg [10:0] grace_cnt_nxt;
  reg rst_active_nxt;
  reg [6:0] rst_cnt_nxt;

  wire wd_tick;
  wire bus_wr;
  wire bus_rd;
  wire wr_ctrl;
  wire hit;
  wire timeout;
  wire grace_done;
  wire clear_req;
  wire wd_reset_fire;
  wire wake_fire;

  // ----------------------------------------------------------------
  // Bus decode and watchdog tick
  // ----------------------------------------------------------------
  // Watchdog clock sampled as a slow input, one tick per rising edge
  assign wd_tick = wdc_sync_r[1] & ~wdc_sync_r[2];
  assign bus_wr = psel & penable & pwrite;
  assign bus_rd = psel & ~penable & ~pwrite;
  assign wr_ctrl = bus_wr & (paddr == `WDT_ADDR_CONTROL);
  assign hit = (paddr == `WDT_ADDR_CONTROL) | (paddr == `WDT_ADDR_COUNT) |
               (paddr == `WDT_ADDR_PWR);
  assign timeout = wd_enable_r & wd_tick & (count_r == interval_last(interval_select_r));
  assign grace_done = grace_active_r & wd_tick &
                      (grace_cnt_r == GRACE_CLKS[10:0] - 11'h001);
  assign clear_req = wr_ctrl & pwdata[`WDT_BIT_CLEAR];
  assign wd_reset_fire = grace_done & ~counter_clear_r & wd_reset_enable_r;
  assign wake_fire = timeout & power_down & wake_enable_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdc_sync_r <= 3'h0;
    end else begin
      wdc_sync_r <= {wdc_sync_r[1:0], wd_clock};
    end
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_enable_r <= 1'b0;
      wd_reset_enable_r <= 1'b0;
      timeout_int_enable_r <= 1'b0;
      wake_enable_r <= 1'b0;
      interval_select_r <= 3'h0;
    end else if (wr_ctrl) begin
      wd_enable_r <= pwdata[`WDT_BIT_ENABLE];
      wd_reset_enable_r <= pwdata[`WDT_BIT_RST_EN];
      timeout_int_enable_r <= pwdata[`WDT_BIT_INT_EN];
      wake_enable_r <= pwdata[`WDT_BIT_WAKE_EN];
      interval_select_r <= pwdata[`WDT_SEL_MSB:`WDT_SEL_LSB];
    end
  end

  // Clear bit holds until the counter has been zeroed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_clear_r <= 1'b0;
    end else if (clear_req) begin
      counter_clear_r <= 1'b1;
    end else if (counter_clear_r) begin
      counter_clear_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always @* begin
    count_nxt = count_r;
    if (counter_clear_r) begin
      count_nxt = {CNT_W{1'b0}};
    end else if (wd_enable_r & wd_tick) begin
      count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= {CNT_W{1'b0}};
    end else begin
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Set wins over a write-one clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_int_flag_r <= 1'b0;
    end else if (timeout) begin
      timeout_int_flag_r <= 1'b1;
    end else if (wr_ctrl & pwdata[`WDT_BIT_INT_FLAG]) begin
      timeout_int_flag_r <= 1'b0;
    end
  end

  // Only presetn or a write-one clears this flag, never the watchdog reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_reset_flag_r <= 1'b0;
    end else if (wd_reset_fire) begin
      wd_reset_flag_r <= 1'b1;
    end else if (wr_ctrl & pwdata[`WDT_BIT_RST_FLAG]) begin
      wd_reset_flag_r <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_flag_r <= 1'b0;
    end else if (wake_fire) begin
      wake_flag_r <= 1'b1;
    end else if (wr_ctrl & pwdata[`WDT_BIT_WAKE_FLAG]) begin
      wake_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Grace delay
  // ----------------------------------------------------------------
  always @* begin
    grace_active_nxt = grace_active_r;
    grace_cnt_nxt = grace_cnt_r;
    if (counter_clear_r | ~wd_enable_r) begin
      grace_active_nxt = 1'b0;
      grace_cnt_nxt = 11'h000;
    end else if (timeout) begin
      grace_active_nxt = 1'b1;
      grace_cnt_nxt = 11'h000;
    end else if (grace_done) begin
      grace_active_nxt = 1'b0;
    end else if (grace_active_r & wd_tick) begin
      grace_cnt_nxt = grace_cnt_r + 11'h001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grace_active_r <= 1'b0;
      grace_cnt_r <= 11'h000;
    end else begin
      grace_active_r <= grace_active_nxt;
      grace_cnt_r <= grace_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Chip reset pulse
  // ----------------------------------------------------------------
  always @* begin
    rst_active_nxt = rst_active_r;
    rst_cnt_nxt = rst_cnt_r;
    if (wd_reset_fire) begin
      rst_active_nxt = 1'b1;
      rst_cnt_nxt = 7'h00;
    end else if (rst_active_r & wd_tick) begin
      if (rst_cnt_r == RST_CLKS[6:0] - 7'h01) begin
        rst_active_nxt = 1'b0;
      end else begin
        rst_cnt_nxt = rst_cnt_r + 7'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_active_r <= 1'b0;
      rst_cnt_r <= 7'h00;
    end else begin
      rst_active_r <= rst_active_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up request
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req_r <= 1'b0;
    end else begin
      wake_req_r <= wake_fire;
    end
  end

  // ----------------------------------------------------------------
  // APB read data, registered in the setup cycle
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (bus_rd) begin
      prdata_r <= 32'h0000_0000;
      case (paddr)
        `WDT_ADDR_CONTROL: begin
          prdata_r[`WDT_SEL_MSB:`WDT_SEL_LSB] <= interval_select_r;
          prdata_r[`WDT_BIT_ENABLE] <= wd_enable_r;
          prdata_r[`WDT_BIT_INT_EN] <= timeout_int_enable_r;
          prdata_r[`WDT_BIT_WAKE_FLAG] <= wake_flag_r;
          prdata_r[`WDT_BIT_WAKE_EN] <= wake_enable_r;
          prdata_r[`WDT_BIT_RST_FLAG] <= wd_reset_flag_r;
          prdata_r[`WDT_BIT_INT_FLAG] <= timeout_int_flag_r;
          prdata_r[`WDT_BIT_RST_EN] <= wd_reset_enable_r;
          prdata_r[`WDT_BIT_CLEAR] <= counter_clear_r;
        end
        `WDT_ADDR_COUNT: begin
          prdata_r[CNT_W-1:0] <= count_r;
        end
        `WDT_ADDR_PWR: begin
          prdata_r[`WDT_BIT_PWR_DOWN] <= power_down;
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign timeout_irq = timeout_int_flag_r & timeout_int_enable_r;
  assign wake_req = wake_req_r;
  assign chip_reset_n = ~rst_active_r;
  assign reset_vector = `WDT_RST_VECTOR;

endmodule // wdt_timer

/* File: verilog/wdt_defs.vh */
// Constants for the watchdog timer block
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define WDT_ADDR_CONTROL 12'h000
`define WDT_ADDR_COUNT 12'h004
`define WDT_ADDR_PWR 12'h008

// ----------------------------------------------------------------
// Control register fields, then the power register field
// ----------------------------------------------------------------
`define WDT_BIT_CLEAR 0
`define WDT_BIT_RST_EN 1
`define WDT_BIT_INT_FLAG 2
`define WDT_BIT_RST_FLAG 3
`define WDT_BIT_WAKE_EN 4
`define WDT_BIT_WAKE_FLAG 5
`define WDT_BIT_INT_EN 6
`define WDT_BIT_ENABLE 7
`define WDT_SEL_LSB 8
`define WDT_SEL_MSB 10
`define WDT_BIT_PWR_DOWN 0

// ----------------------------------------------------------------
// Widths, timing in watchdog clocks, and the reset vector
// ----------------------------------------------------------------
`define WDT_CNT_W 18
`define WDT_GRACE_CLKS 1024
`define WDT_RST_CLKS 63
`define WDT_RST_VECTOR 32'h0000_0000

`endif

/* File: verification/wdt_timer_assertions.sv */
// Port checker for the watchdog block
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module wdt_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire power_down,
  input wire timeout_irq,
  input wire wake_req,
  input wire chip_reset_n,
  input wire [31:0] reset_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  err_unmapped_a: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
    else $error("no pslverr");
  vector_zero_a: assert property (reset_vector == 32'h0) else $error("bad vector");
  irq_hold_a: assert property ($fell(timeout_irq) |-> $past(psel && penable && pwrite))
    else $error("irq dropped");
  wake_pulse_a: assert property (wake_req |=> !wake_req) else $error("wake too long");
  wake_pd_a: assert property (wake_req |-> $past(power_down)) else $error("wake awake");
  rst_min_a: assert property ($fell(chip_reset_n) |=> !chip_reset_n [*8])
    else $error("reset short");
  rst_max_a: assert property ($fell(chip_reset_n) |-> ##[1:200] chip_reset_n)
    else $error("reset long");
  rd_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
  cover property ($fell(chip_reset_n));
  cover property (wake_req);
  cover property ($fell(timeout_irq));
endmodule // wdt_chk
bind wdt_timer wdt_chk wdt_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .power_down, .timeout_irq, .wake_req, .chip_reset_n, .reset_vector);

/* File: verification/wdt_timer_tb.sv */
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAIT(c, l) begin n = 0; #1; while (!(c) && n < l) begin @(posedge pclk); #1; n++; end \
  if (n >= l) begin n_mismatch++; results; end end
// ----------------------------------------
// Bench
// ----------------------------------------
module wdt_timer_tb;
  reg pclk = 0, presetn = 0, wd_clock = 0, psel = 0, penable = 0, pwrite = 0, power_down = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [1:0] dv = 0;
  reg er;
  wire [31:0] prdata, reset_vector;
  wire pready, pslverr, timeout_irq, wake_req, chip_reset_n;
  int n_mismatch = 0, comparisons = 0, n;
  always #12.5 pclk = ~pclk;
  // Watchdog tick every 8 pclk
  always @(posedge pclk) begin
    dv <= dv + 1;
    if (dv == 0) wd_clock <= ~wd_clock;
  end
  wdt_timer #(.GRACE_CLKS(8), .RST_CLKS(4)) wdt_timer_i (.pclk, .presetn, .wd_clock, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_down, .timeout_irq,
    .wake_req, .chip_reset_n, .reset_vector);
  task results;
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic xfer(input bit w, input [11:0] a, input [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin n_mismatch++; results; end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    xfer(0, 12'h00c, 0);
    `CHK("unmapped", 33'h1_0000_0000, {er, rd})
    for (int s = 0; s < 8; s++) begin
      xfer(1, 0, {21'h0, s[2:0], 8'h0});
      xfer(0, 0, 0);
      `CHK("sel", s[2:0], rd[10:8])
    end
    for (int s = 0; s < 3; s++) begin
      xfer(1, 0, {21'h0, s[2:0], 8'hc5});
      `WAIT(timeout_irq, 20000)
      `CHK("period", 1'b1, n > (112 << 2 * s) && n < (144 << 2 * s))
      xfer(0, 0, 0);
      `CHK("flag", 1'b1, rd[2])
      `CHK("irq", 1'b1, timeout_irq)
    end
    xfer(1, 0, 32'h81);
    xfer(0, 4, 0);
    `CHK("cnt", 1'b1, rd < 4)
    `CHK("irqmask", 1'b0, timeout_irq)
    xfer(0, 0, 0);
    `CHK("clr", 1'b0, rd[0])
    xfer(1, 0, 32'hc7);
    `WAIT(timeout_irq, 400)
    repeat (40) @(posedge pclk);
    xfer(1, 0, 32'hc7);
    n = 0;
    repeat (150) begin @(posedge pclk); if (!chip_reset_n) n++; end
    `CHK("grace", 1'b1, n == 0)
    `WAIT(!chip_reset_n, 400)
    `WAIT(chip_reset_n, 200)
    `CHK("rstlen", 1'b1, n >= 28 && n <= 36)
    xfer(0, 0, 0);
    `CHK("rstflag", 1'b1, rd[3])
    power_down <= 1;
    xfer(1, 0, 32'h95);
    `WAIT(wake_req, 300)
    @(posedge pclk); #1;
    `CHK("pulse", 1'b0, wake_req)
    xfer(0, 0, 0);
    `CHK("wakeflag", 1'b1, rd[5])
    xfer(0, 12'h008, 0);
    `CHK("pd", 32'h1, rd)
    `CHK("vector", 32'h0, reset_vector)
    results;
  end
endmodule // wdt_timer_tb
